// ===== hw/dcc_pkg.sv
package dcc_pkg;
    localparam logic [7:0] DCC_ADDR_CONTROL = 8'h00;
    localparam logic [7:0] DCC_ADDR_CODE = 8'h01;
    localparam logic [7:0] DCC_CONTROL_RESET = 8'h00;
    localparam logic [7:0] DCC_CODE_RESET = 8'h00;
    localparam int DCC_BIT_ENABLE = 0;
    localparam int DCC_BIT_PIN_BUFFER_ON = 6;
    localparam int DCC_BIT_KEEP_RUNNING = 7;
    localparam logic [7:0] DCC_CONTROL_WMASK = 8'hC1;
    localparam int DCC_CLK_MHZ = 125;
    // analog settle time after power-up, in ns (plain default)
    localparam int DCC_STARTUP_NS = 1000;
    localparam int DCC_STARTUP_CYC = (DCC_STARTUP_NS * DCC_CLK_MHZ + 999) / 1000;
    localparam int DCC_CNT_W = 8;

    typedef enum logic [1:0] {
        DCC_OFF = 2'b00,
        DCC_WARM = 2'b01,
        DCC_RUN = 2'b10
    } dcc_state_e;
endpackage

// ===== hw/dcc_startup_timer.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_startup_timer
    import dcc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic restart_i,
    input wire logic hold_i,
    output logic done_o
);
    typedef struct packed {
        logic [DCC_CNT_W-1:0] cnt;
        logic done;
    } dcc_tmr_s;

    dcc_tmr_s st_r;
    dcc_tmr_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (hold_i || restart_i) begin
            st_nxt.cnt = DCC_CNT_W'(DCC_STARTUP_CYC - 1);
            st_nxt.done = 1'b0;
        end else if (!st_r.done) begin
            if (st_r.cnt == '0) begin
                st_nxt.done = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign done_o = st_r.done;
endmodule
`default_nettype wire

// ===== hw/dcc_control.sv
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module dcc_control
    import dcc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic standby_i,
    input wire logic power_down_i,
    input wire logic per_clk_avail_i,
    output logic core_power_o,
    output logic [7:0] core_code_o,
    output logic convert_start_o,
    output logic internal_out_valid_o,
    output logic pin_buffer_on_o,
    output logic ready_o
);
    typedef struct packed {
        logic [7:0] control;
        logic [7:0] code;
        logic [7:0] rdata;
        dcc_state_e state;
        logic pending;
        logic start;
        logic power;
        logic buffer;
        logic internal;
        logic [7:0] core_code;
        logic [2:0] slp_meta;
        logic [2:0] slp_sync;
    } dcc_ctl_s;

    dcc_ctl_s st_r;
    dcc_ctl_s st_nxt;
    logic warm_done;
    logic warm_hold;
    logic warm_restart;

    function automatic logic [7:0] dcc_read(input logic [7:0] a, input logic [7:0] ctl, input logic [7:0] cd);
        logic [7:0] v;
        v = 8'h00;
        if (a == DCC_ADDR_CONTROL) begin
            v = ctl & DCC_CONTROL_WMASK;
        end else if (a == DCC_ADDR_CODE) begin
            v = cd;
        end
        return v;
    endfunction

    // sleep inputs come from the power manager outside this clock domain
    logic en_bit;
    logic keep_bit;
    logic buf_bit;
    logic stby_s;
    logic pdown_s;
    logic clk_ok_s;
    logic shut;
    logic wr_ctl;
    logic wr_code;
    logic en_rise;

    always_comb begin
        st_nxt = st_r;
        en_bit = st_r.control[DCC_BIT_ENABLE];
        keep_bit = st_r.control[DCC_BIT_KEEP_RUNNING];
        buf_bit = st_r.control[DCC_BIT_PIN_BUFFER_ON];
        stby_s = st_r.slp_sync[0];
        pdown_s = st_r.slp_sync[1];
        clk_ok_s = st_r.slp_sync[2];
        wr_ctl = wr_i && (addr_i == DCC_ADDR_CONTROL);
        wr_code = wr_i && (addr_i == DCC_ADDR_CODE);
        en_rise = wr_ctl && wdata_i[DCC_BIT_ENABLE] && !en_bit;
        st_nxt.slp_meta = {per_clk_avail_i, power_down_i, standby_i};
        st_nxt.slp_sync = st_r.slp_meta;
        st_nxt.start = 1'b0;
        if (wr_ctl) begin
            st_nxt.control = wdata_i & DCC_CONTROL_WMASK;
        end
        if (wr_code) begin
            st_nxt.code = wdata_i;
        end
        if (rd_i) begin
            st_nxt.rdata = dcc_read(addr_i, st_r.control, st_r.code);
        end
        // shutdown: power down always, standby unless kept running with clock present
        shut = pdown_s || (stby_s && !(keep_bit && clk_ok_s));
        if (wr_code && en_bit) begin
            st_nxt.pending = 1'b1;
        end
        if (en_rise) begin
            st_nxt.pending = 1'b1;
        end
        unique case (st_r.state)
            DCC_OFF: begin
                if (en_bit && !shut) begin
                    st_nxt.state = DCC_WARM;
                end
            end
            DCC_WARM: begin
                if (!en_bit || shut) begin
                    st_nxt.state = DCC_OFF;
                end else if (warm_done) begin
                    st_nxt.state = DCC_RUN;
                end
            end
            DCC_RUN: begin
                if (!en_bit || shut) begin
                    st_nxt.state = DCC_OFF;
                end else if (st_r.pending || (wr_code && en_bit)) begin
                    // the code write lands in the core the same cycle it is stored
                    st_nxt.start = 1'b1;
                    st_nxt.core_code = wr_code ? wdata_i : st_r.code;
                    st_nxt.pending = 1'b0;
                end
            end
            default: begin
                st_nxt.state = DCC_OFF;
            end
        endcase
        if (!en_bit && !(wr_ctl && wdata_i[DCC_BIT_ENABLE])) begin
            st_nxt.pending = 1'b0;
        end
        // after a shutdown the held code is converted again once warm
        if (st_r.state != DCC_RUN && st_nxt.state == DCC_WARM) begin
            st_nxt.pending = 1'b1;
        end
        st_nxt.power = (st_nxt.state != DCC_OFF);
        st_nxt.internal = (st_nxt.state == DCC_RUN);
        // buffer follows power gated by the pin-buffer bit, not the run state; its analog output is meaningless while warming
        st_nxt.buffer = st_nxt.power && st_nxt.control[DCC_BIT_PIN_BUFFER_ON];
    end

    assign warm_hold = (st_r.state != DCC_WARM);
    assign warm_restart = 1'b0;

    dcc_startup_timer u_timer (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .restart_i(warm_restart),
        .hold_i(warm_hold),
        .done_o(warm_done)
    );

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
            st_r.control <= DCC_CONTROL_RESET;
            st_r.code <= DCC_CODE_RESET;
            st_r.state <= DCC_OFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o = st_r.rdata;
    assign core_power_o = st_r.power;
    assign core_code_o = st_r.core_code;
    assign convert_start_o = st_r.start;
    assign internal_out_valid_o = st_r.internal;
    assign pin_buffer_on_o = st_r.buffer;
    assign ready_o = st_r.internal;
endmodule
`default_nettype wire

// ===== sim/dcc_control_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_control_asserts
    import dcc_pkg::*;
(
    input wire logic mclk_i, rst_n_i, wr_i, rd_i, standby_i, power_down_i, per_clk_avail_i,
    input wire logic core_power_o, convert_start_o, internal_out_valid_o, pin_buffer_on_o, ready_o,
    input wire logic [7:0] addr_i, wdata_i, rdata_o, core_code_o
);
    // shadow of the control register, rebuilt from the bus alone
    logic [7:0] ctl_r;
    wire logic cw = wr_i && addr_i == DCC_ADDR_CONTROL;
    always_ff @(posedge mclk_i) begin
        ctl_r <= !rst_n_i ? 8'h00 : (cw ? wdata_i : ctl_r);
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence code_wr_s; internal_out_valid_o && wr_i && addr_i == DCC_ADDR_CODE && !standby_i && !power_down_i; endsequence
    sequence start_s; convert_start_o && core_code_o == $past(wdata_i); endsequence
    a_ready_same: assert property (ready_o == internal_out_valid_o) else $error("ready differs");
    a_valid_power: assert property (internal_out_valid_o |-> core_power_o) else $error("valid unpowered");
    a_code_start: assert property (code_wr_s |=> start_s) else $error("code write no start");
    a_off_quiet: assert property (!core_power_o |=> !convert_start_o) else $error("start while off");
    a_buf_bit: assert property (pin_buffer_on_o == (core_power_o && ctl_r[6])) else $error("buffer wrong");
    a_enable_off: assert property (cw && !wdata_i[0] |-> ##2 !core_power_o) else $error("not disabled");
    a_pd_off: assert property (power_down_i [*5] |-> !core_power_o) else $error("on in power down");
    a_stby_off: assert property ((standby_i && !ctl_r[7]) [*5] |-> !core_power_o) else $error("on in standby");
    a_stby_run: assert property (internal_out_valid_o && standby_i && ctl_r[7] && ctl_r[0] && per_clk_avail_i && !power_down_i
        && !wr_i |=> internal_out_valid_o) else $error("stopped in standby");
    a_warm_wait: assert property ($rose(core_power_o) |-> !internal_out_valid_o [*8]) else $error("no warm-up");
    a_read_mask: assert property (rd_i && !addr_i[0] |=> rdata_o[5:1] == 5'h00) else $error("unused bits set");
endmodule
bind dcc_control dcc_control_asserts dcc_control_asserts_inst (.*);
`default_nettype wire

// ===== sim/dcc_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %0t %h %h", $time, g, e); end end
module dcc_control_bench
    import dcc_pkg::*;
;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, standby_i = 1'b0, power_down_i = 1'b0;
    logic per_clk_avail_i = 1'b1, core_power_o, convert_start_o, internal_out_valid_o, pin_buffer_on_o, ready_o;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, core_code_o, d;
    int fail_count = 0, checked = 0;
    always #4 mclk_i = ~mclk_i;
    dcc_control dcc_control_inst (.*);
    function automatic logic [7:0] ctl_exp(logic [7:0] v); return v & DCC_CONTROL_WMASK; endfunction
    task automatic tick(int n); repeat (n) @(posedge mclk_i); #1; endtask
    task automatic wr(logic [7:0] a, v);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, e);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 `CHK(rdata_o, e)
    endtask
    // bounded: warm-up is about 125 cycles
    task automatic wait_start(logic [7:0] c);
        for (int n = 0; n < 400 && convert_start_o !== 1'b1; n++) tick(1);
        `CHK({convert_start_o, core_code_o}, {1'b1, c})
    endtask
    task automatic close_out;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge mclk_i);
        fail_count++;
        close_out;
    end
    initial begin
        void'($urandom(32'h03E7));
        repeat (10) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rd(DCC_ADDR_CONTROL, DCC_CONTROL_RESET);
        rd(DCC_ADDR_CODE, DCC_CODE_RESET);
        d = 8'($urandom);
        wr(DCC_ADDR_CONTROL, d & 8'h3E);
        rd(DCC_ADDR_CONTROL, ctl_exp(d & 8'h3E));
        wr(8'h02, 8'hFF);
        rd(8'h02, 8'h00);
        d = 8'($urandom);
        wr(DCC_ADDR_CODE, d);
        rd(DCC_ADDR_CODE, d);
        tick(3);
        `CHK(convert_start_o, 1'b0)
        wr(DCC_ADDR_CONTROL, 8'h41);
        wait_start(d);
        `CHK(pin_buffer_on_o, 1'b1)
        repeat (8) begin
            d = 8'($urandom);
            wr(DCC_ADDR_CODE, d);
            #1;
            `CHK({convert_start_o, core_code_o}, {1'b1, d})
        end
        wr(DCC_ADDR_CONTROL, 8'h01);
        tick(2);
        `CHK({pin_buffer_on_o, internal_out_valid_o}, 2'b01)
        wr(DCC_ADDR_CONTROL, 8'($urandom) & 8'h3E | 8'h41);
        rd(DCC_ADDR_CONTROL, 8'h41);
        @(posedge mclk_i) standby_i <= 1'b1;
        tick(6);
        `CHK({core_power_o, pin_buffer_on_o}, 2'b00)
        @(posedge mclk_i) standby_i <= 1'b0;
        tick(6);
        `CHK({core_power_o, pin_buffer_on_o, internal_out_valid_o}, 3'b110)
        wait_start(d);
        wr(DCC_ADDR_CONTROL, 8'hC1);
        @(posedge mclk_i) standby_i <= 1'b1;
        tick(8);
        `CHK(internal_out_valid_o, 1'b1)
        @(posedge mclk_i) per_clk_avail_i <= 1'b0;
        tick(6);
        `CHK(core_power_o, 1'b0)
        @(posedge mclk_i) power_down_i <= 1'b1;
        standby_i <= 1'b0;
        per_clk_avail_i <= 1'b1;
        tick(6);
        `CHK(core_power_o, 1'b0)
        @(posedge mclk_i) power_down_i <= 1'b0;
        wait_start(d);
        wr(DCC_ADDR_CONTROL, 8'h00);
        tick(1);
        `CHK(core_power_o, 1'b0)
        wr(DCC_ADDR_CODE, ~d);
        tick(3);
        `CHK(convert_start_o, 1'b0)
        close_out;
    end
endmodule
`default_nettype wire
